// [shared/supervisor_pkg.sv]
// Purpose: constants, types and register layout of the service window supervisor
// Assumes: 10 MHz reference clock, 32-bit classic Wishbone register port
// Notes:   window, hold and idle counts are in instruction cycles, the clock monitor counts reference cycles
package supervisor_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned INSTR_TIME_NS  = 1000;
  localparam int unsigned INSTR_DIV      = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLKMON_TIME_NS = 100_000_000;
  localparam int unsigned CLKMON_CYCLES  = CLKMON_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 8;
  localparam int unsigned MON_W          = 20;

  // service window, in instruction cycles
  localparam int unsigned WIN_W          = 17;
  localparam logic [16:0] LOWER_LIMIT    = 17'h00800;
  localparam logic [16:0] UPPER_BASE     = 17'h02000;
  localparam logic [1:0]  WIN_RESET      = 2'h3;
  localparam logic        CLKMON_RESET   = 1'b1;
  localparam logic [4:0]  SERVICE_KEY    = 5'h0C;
  localparam logic [4:0]  FAULT_HOLD     = 5'h10;

  // idle timer
  localparam int unsigned IDLE_W         = 16;
  localparam int unsigned IDLE_BIT       = 12;

  // register byte offsets
  localparam int unsigned ADR_W          = 8;
  localparam logic [7:0]  OFS_SERVICE    = 8'h00;
  localparam logic [7:0]  OFS_CTRL       = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_IDLE       = 8'h0C;

  // control register bits
  localparam int unsigned CTRL_HALT      = 0;
  localparam int unsigned CTRL_IDLE      = 1;
  localparam int unsigned CTRL_DELAY     = 2;
  localparam int unsigned CTRL_XTAL      = 3;
  localparam logic        DELAY_RESET    = 1'b0;
  localparam logic        XTAL_RESET     = 1'b0;

  // status register bits
  localparam int unsigned ST_FAULT       = 0;
  localparam int unsigned ST_PEND        = 1;
  localparam int unsigned ST_HALT        = 2;
  localparam int unsigned ST_IDLE        = 3;
  localparam int unsigned ST_FIRST       = 4;
  localparam int unsigned ST_CMERR       = 5;
  localparam int unsigned ST_COUNT_LSB   = 8;

  // layout of the service_key_register byte
  typedef struct packed {
    logic [1:0] window;
    logic [4:0] key;
    logic       clkmon;
  } service_word_type;

  typedef enum {F_ARMED, F_DRIVE, F_STRETCH, F_RELEASE} fault_state_type;

endpackage

// [design/idle_interval_timer.sv]
// Purpose: free_running_idle_timer with its idle_timer_pending_flag
// Assumes: tick is the running instruction-cycle enable
// Notes:   count is cleared only by power-on reset, never by the system reset
`timescale 1ns/1ps
`default_nettype none
module idle_interval_timer
  import supervisor_pkg::*;
(
  // clock and resets
  input  wire logic              clk,
  input  wire logic              por_rst,
  input  wire logic              sys_rst,
  // control
  input  wire logic              tick,
  input  wire logic              clr,
  // state
  output var  logic [IDLE_W-1:0] count,
  output var  logic              pend,
  output var  logic              toggle
);

  logic [IDLE_W-1:0] count_q;
  logic              pend_q;

  // the watched bit changes on the next tick when all lower bits are ones
  assign toggle = tick & (&count_q[IDLE_BIT-1:0]);
  assign count  = count_q;
  assign pend   = pend_q;

  // counter survives an external reset
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + 1'b1;
    end
  end

  // set beats clear so no toggle is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (toggle) begin
      pend_q <= 1'b1;
    end else if (clr) begin
      pend_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [design/service_window_supervisor.sv]
// Purpose: service window supervisor with clock monitor and active-low fault pin
// Assumes: pin and wake inputs synchronous to REF_CLK; open-drain pin resolved outside
// Notes:   registers over classic Wishbone, one ack one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module service_window_supervisor
  import supervisor_pkg::*;
#(
  parameter int unsigned INSTR_DIV_P     = INSTR_DIV,
  parameter int unsigned CLKMON_CYCLES_P = CLKMON_CYCLES
) (
  // clock and resets
  input  wire logic             REF_CLK,
  input  wire logic             SYS_RST,
  input  wire logic             POR_RST,
  // wishbone slave
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output var  logic [31:0]      WB_DAT_O,
  output var  logic             WB_ACK_O,
  // wake from low-power modes
  input  wire logic             WAKE_I,
  // supervisor_fault_output pin
  input  wire logic             FAULT_PIN_I,
  output var  logic             FAULT_PIN_O,
  output var  logic             FAULT_PIN_OE_N,
  // idle_timer_pending_flag
  output var  logic             IDLE_PEND
);

  logic [DIV_W-1:0]  div_q;
  logic [DIV_W-1:0]  div_d;
  logic [MON_W-1:0]  mon_q;
  logic [MON_W-1:0]  mon_d;
  logic [WIN_W-1:0]  cnt_q;
  logic [WIN_W-1:0]  cnt_d;
  logic [4:0]        hold_q;
  logic [4:0]        hold_d;
  fault_state_type   state_q;
  fault_state_type   state_d;
  logic [1:0]        win_q;
  logic              cm_q;
  logic              first_q;
  logic              halt_q;
  logic              idle_q;
  logic              delay_q;
  logic              xtal_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              drive_q;
  logic              pend_q;
  logic [IDLE_W-1:0] idle_count;
  logic              idle_pend;
  logic              idle_toggle;
  logic [31:0]       status_word;

  // instruction-cycle divider; core tick stops with the clock in halt
  wire tick_free = (div_q == DIV_W'(INSTR_DIV_P - 1));
  wire tick_core = tick_free & ~halt_q;
  assign div_d = tick_free ? '0 : div_q + 1'b1;

  // clock monitor: reference cycles since the last core tick
  wire mon_full = (mon_q == MON_W'(CLKMON_CYCLES_P));
  wire cm_err   = cm_q & mon_full;
  assign mon_d  = tick_core ? '0 : (mon_full ? mon_q : mon_q + 1'b1);

  // bus decode
  wire req      = WB_CYC_I & WB_STB_I & ~ack_q;
  wire wr       = req & WB_WE_I & WB_SEL_I[0];
  wire hit_svc  = (WB_ADR_I == OFS_SERVICE);
  wire hit_ctrl = (WB_ADR_I == OFS_CTRL);
  wire hit_stat = (WB_ADR_I == OFS_STATUS);
  wire hit_idle = (WB_ADR_I == OFS_IDLE);

  // service write check
  wire fault_active       = (state_q != F_ARMED);
  wire              svc_write = wr & hit_svc & ~fault_active;
  service_word_type svc_word;
  assign svc_word = service_word_type'(WB_DAT_I[7:0]);
  wire key_ok   = (svc_word.key == SERVICE_KEY);
  wire field_ok = (svc_word.window == win_q) & (svc_word.clkmon == cm_q);
  wire match_ok = key_ok & (first_q | field_ok);
  wire early    = ~first_q & (cnt_q < LOWER_LIMIT);
  wire svc_good = svc_write & match_ok & ~early;
  wire svc_bad  = svc_write & ~svc_good;

  // upper limit doubles per window code, 8k up to 64k
  wire [WIN_W-1:0] upper_lim = UPPER_BASE << win_q;
  wire wd_run = ~fault_active & ~halt_q & ~idle_q;
  wire late   = wd_run & tick_core & (cnt_q == upper_lim - 1'b1);
  wire fault_trig = svc_bad | late | cm_err;

  // low-power mode entry and exit
  wire ctrl_wr    = wr & hit_ctrl;
  wire halt_enter = ctrl_wr & WB_DAT_I[CTRL_HALT] & ~idle_q;
  wire idle_enter = ctrl_wr & WB_DAT_I[CTRL_IDLE] & ~WB_DAT_I[CTRL_HALT] & ~halt_q;
  wire halt_exit  = halt_q & WAKE_I;
  wire idle_exit  = idle_q & (WAKE_I | idle_toggle);
  wire halt_restart = halt_exit & (xtal_q | delay_q);
  wire pend_clr   = wr & hit_stat & WB_DAT_I[ST_PEND];

  // window counter; halt without restart simply keeps its value
  always_comb begin
    if (fault_active) begin
      cnt_d = '0;
    end else if (svc_good | idle_exit | halt_restart) begin
      cnt_d = '0;
    end else if (wd_run & tick_core) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // fault sequencer: drive, stretch after the pin falls, wait for it high
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    case (state_q)
      F_ARMED: begin
        if (fault_trig) begin
          state_d = F_DRIVE;
        end
      end
      F_DRIVE: begin
        hold_d = '0;
        if (~FAULT_PIN_I & ~cm_err) begin
          state_d = F_STRETCH;
        end
      end
      F_STRETCH: begin
        if (cm_err) begin
          hold_d = '0; // monitor error keeps the pin low
        end else if (hold_q == FAULT_HOLD) begin
          state_d = F_RELEASE;
        end else if (tick_free) begin
          hold_d = hold_q + 1'b1;
        end
      end
      F_RELEASE: begin
        if (FAULT_PIN_I) begin
          state_d = F_ARMED;
        end
      end
      default: begin
        state_d = F_ARMED;
      end
    endcase
  end

  wire drive_d = (state_d == F_DRIVE) | (state_d == F_STRETCH);

  // read data; key bits never leave the block
  always_comb begin
    status_word                            = '0;
    status_word[ST_FAULT]                  = fault_active;
    status_word[ST_PEND]                   = idle_pend;
    status_word[ST_HALT]                   = halt_q;
    status_word[ST_IDLE]                   = idle_q;
    status_word[ST_FIRST]                  = first_q;
    status_word[ST_CMERR]                  = cm_err;
    status_word[ST_COUNT_LSB +: WIN_W]     = cnt_q;
  end

  wire [31:0] svc_read  = {24'h000000, win_q, 5'h00, cm_q};
  wire [31:0] ctrl_read = {28'h0000000, xtal_q, delay_q, idle_q, halt_q};
  wire [31:0] idle_read = {{(32 - IDLE_W){1'b0}}, idle_count};
  wire [31:0] rd_data   = hit_svc  ? svc_read  :
                          hit_ctrl ? ctrl_read :
                          hit_stat ? status_word :
                          hit_idle ? idle_read : 32'h00000000;

  // timing and supervisor state; async reset parks every detector
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_q   <= '0;
      mon_q   <= '0;
      cnt_q   <= '0;
      hold_q  <= '0;
      state_q <= F_ARMED;
    end else begin
      div_q   <= div_d;
      mon_q   <= mon_d;
      cnt_q   <= cnt_d;
      hold_q  <= hold_d;
      state_q <= state_d;
    end
  end

  // latched service choices, first write only
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      win_q   <= WIN_RESET;
      cm_q    <= CLKMON_RESET;
      first_q <= 1'b1;
    end else if (svc_good & first_q) begin
      win_q   <= svc_word.window;
      cm_q    <= svc_word.clkmon;
      first_q <= 1'b0;
    end
  end

  // low-power modes and oscillator options
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_q  <= 1'b0;
      idle_q  <= 1'b0;
      delay_q <= DELAY_RESET;
      xtal_q  <= XTAL_RESET;
    end else begin
      halt_q <= halt_exit ? 1'b0 : (halt_q | halt_enter);
      idle_q <= idle_exit ? 1'b0 : (idle_q | idle_enter);
      if (ctrl_wr) begin
        delay_q <= WB_DAT_I[CTRL_DELAY];
        xtal_q  <= WB_DAT_I[CTRL_XTAL];
      end
    end
  end

  // bus answer and pin outputs, all registered
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q   <= 1'b0;
      dat_q   <= '0;
      drive_q <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      ack_q   <= req;
      dat_q   <= req ? rd_data : dat_q;
      drive_q <= drive_d;
      pend_q  <= idle_pend;
    end
  end

  assign WB_ACK_O       = ack_q;
  assign WB_DAT_O       = dat_q;
  assign FAULT_PIN_O    = 1'b0 & drive_q; // open drain: only ever pulls low
  assign FAULT_PIN_OE_N = ~drive_q;
  assign IDLE_PEND      = pend_q;

  // idle timer keeps running in idle, stops with the clock in halt
  idle_interval_timer u_idle (
    .clk     (REF_CLK),
    .por_rst (POR_RST),
    .sys_rst (SYS_RST),
    .tick    (tick_core),
    .clr     (pend_clr),
    .count   (idle_count),
    .pend    (idle_pend),
    .toggle  (idle_toggle)
  );

endmodule
`default_nettype wire

// [verification/service_window_supervisor_chk.sv]
// Purpose: port-level checks of the service window supervisor
// Assumes: fault wire resolved with a pull-up outside the block
// Notes:   stretch bound scales with the instruction divider
`timescale 1ns/1ps
`default_nettype none
module service_window_supervisor_chk
  import supervisor_pkg::*;
#(
  parameter int unsigned INSTR_DIV_P = INSTR_DIV
) (
  // clock and reset
  input wire logic             REF_CLK,
  input wire logic             SYS_RST,
  // wishbone
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0]       WB_SEL_I,
  input wire logic [31:0]      WB_DAT_I,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic             WB_ACK_O,
  // fault wire
  input wire logic             FAULT_PIN_I,
  input wire logic             FAULT_PIN_O,
  input wire logic             FAULT_PIN_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // cycles the wire has been pulled low, saturating so a stuck pin cannot wrap
  logic [15:0] low_q;
  // the reset branch holds only the reset; a released wire clears the count on the clock
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_q <= 16'h0000;
    end else if (FAULT_PIN_OE_N) begin
      low_q <= 16'h0000;
    end else if (low_q != 16'hFFFF) begin
      low_q <= low_q + 16'h0001;
    end
  end

  // request taken, and a keyed write with a wrong key while armed
  sequence s_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_bad_key;
    s_taken ##0 WB_WE_I && WB_SEL_I[0] && WB_ADR_I == OFS_SERVICE
      ##0 WB_DAT_I[5:1] != SERVICE_KEY && FAULT_PIN_OE_N && FAULT_PIN_I && $past(FAULT_PIN_I);
  endsequence

  property p_ack_once;
    s_taken |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  property p_ack_cause;
    $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
  endproperty
  property p_reset_quiet;
    $fell(SYS_RST) |-> FAULT_PIN_OE_N && !WB_ACK_O;
  endproperty
  property p_bad_key;
    s_bad_key |=> !FAULT_PIN_OE_N;
  endproperty
  property p_key_hidden;
    WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_SERVICE |-> WB_DAT_O[5:1] == 5'h00;
  endproperty
  property p_stretch;
    $rose(FAULT_PIN_OE_N) |-> low_q >= 16 * INSTR_DIV_P;
  endproperty
  property p_drive_low;
    !FAULT_PIN_OE_N |-> !FAULT_PIN_O;
  endproperty
  property p_unmapped;
    WB_ACK_O && !WB_WE_I && WB_ADR_I[7:4] != 4'h0 |-> WB_DAT_O == 32'h0;
  endproperty

  a_ack_once:    assert property (p_ack_once) else $error("ack not a single pulse");
  a_ack_cause:   assert property (p_ack_cause) else $error("ack without request");
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  a_bad_key:     assert property (p_bad_key) else $error("bad key not faulted");
  a_key_hidden:  assert property (p_key_hidden) else $error("key visible");
  a_stretch:     assert property (p_stretch) else $error("fault too short");
  a_drive_low:   assert property (p_drive_low) else $error("fault pin not low");
  a_unmapped:    assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind service_window_supervisor service_window_supervisor_chk #(.INSTR_DIV_P(INSTR_DIV_P)) u_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FAULT_PIN_I(FAULT_PIN_I),
  .FAULT_PIN_O(FAULT_PIN_O), .FAULT_PIN_OE_N(FAULT_PIN_OE_N));
`default_nettype wire

// [verification/fault_wire_model.sv]
// Purpose: external reset logic on the fault wire
// Assumes: open-drain wire with a weak pull-up
// Notes:   counts every fault event seen on the wire
`timescale 1ns/1ps
`default_nettype none
module fault_wire_model (
  // fault wire
  input  wire logic oe_n,
  output var  logic pin,
  // event count
  output var  int   events
);
  // pull-up wins whenever nobody sinks the wire
  assign pin = oe_n ? 1'b1 : 1'b0;
  initial events = 0;
  // each falling edge is one reset request
  always @(negedge pin) events = events + 1;
endmodule
`default_nettype wire

// [verification/service_window_supervisor_bench.sv]
// Purpose: self-checking bench of the service window supervisor
// Assumes: one instruction tick per clock, short clock-monitor limit
// Notes:   expectations come from the integer model kept here
`timescale 1ns/1ps
`default_nettype none
module service_window_supervisor_bench import supervisor_pkg::*;;
  logic        clk = 0, sys_rst = 1, por_rst = 1, cyc = 0, stb = 0, we = 0, wake = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, pin_o, oe_n, pend, pin;
  logic [31:0] bad [3] = '{32'h0, 32'hD8, 32'h19};
  int          events, mismatches = 0, n_tests = 0, waited, c, n, k;
  int          m_win = 3, m_cm = 1;

  always #50 clk = ~clk;

  // short divider and monitor limit keep the run well under budget
  service_window_supervisor #(.INSTR_DIV_P(1), .CLKMON_CYCLES_P(64)) DUT (
    .REF_CLK(clk), .SYS_RST(sys_rst), .POR_RST(por_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WAKE_I(wake), .FAULT_PIN_I(pin), .FAULT_PIN_O(pin_o),
    .FAULT_PIN_OE_N(oe_n), .IDLE_PEND(pend));
  fault_wire_model u_wire (.oe_n(oe_n), .pin(pin), .events(events));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_in(input string what, input int lo, input int hi, input logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    check("bus ack", 1, ack);
    if (ack !== 1'b1) complete_run();
  endtask

  // bounded wait for the fault wire to reach a level
  task automatic wait_oe(input logic lvl, input int lim);
    waited = 0;
    while (oe_n !== lvl && waited < lim) begin
      @(posedge clk);
      waited++;
    end
    check("fault enable", lvl, oe_n);
    if (oe_n !== lvl) complete_run();
  endtask

  // service past the lower limit, random slack
  task automatic serve(input logic [31:0] d);
    repeat (2100 + $urandom % 300) @(posedge clk);
    wb(1, OFS_SERVICE, d);
  endtask

  task automatic pulse_wake();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
  endtask

  function automatic logic [31:0] exp_svc();
    return {24'h0, 2'(m_win), 5'h00, 1'(m_cm)};
  endfunction

  initial begin
    void'($urandom(82));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    wb(0, OFS_SERVICE, 0);
    check("service", exp_svc(), q);
    wb(0, OFS_STATUS, 0);
    check("first pending", 1, q[ST_FIRST]);
    // first service inside the lower limit
    wb(1, OFS_SERVICE, 32'h18);
    m_win = 0;
    m_cm = 0;
    repeat (3) @(posedge clk);
    check("fault enable", 1, oe_n);
    wb(0, OFS_SERVICE, 0);
    check("service", exp_svc(), q);
    wb(0, 8'h10, 0);
    check("unmapped", 0, q);
    serve(32'h18);
    wb(0, OFS_STATUS, 0);
    check_in("count restart", 0, 10, q[24:8]);
    $display("test first service done");
    // key, window and monitor mismatches
    for (int i = 0; i < 3; i++) begin
      k = $urandom % 31;
      if (k >= 12) k++;
      bad[0] = {24'h0, 2'h0, 5'(k), 1'b0};
      serve(bad[i]);
      wait_oe(0, 3);
      wait_oe(1, 200);
      check_in("stretch", 12, 40, waited);
      repeat (3) @(posedge clk);
      wb(0, OFS_SERVICE, 0);
      check("service", exp_svc(), q);
    end
    $display("test mismatch done");
    serve(32'h18);
    repeat (100) @(posedge clk);
    wb(1, OFS_SERVICE, 32'h18);
    wait_oe(0, 3);
    wait_oe(1, 200);
    repeat (3) @(posedge clk);
    wait_oe(0, 9000);
    check_in("late count", 8180, 8195, waited);
    wait_oe(1, 200);
    $display("test limits done");
    // pending flag phase, then idle with the detector paused
    wb(1, OFS_STATUS, 32'h2);
    n = 0;
    while (pend !== 1'b1 && n < 4200) begin
      @(posedge clk);
      n++;
    end
    check("idle pending", 1, pend);
    wb(1, OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    check("idle pending", 0, pend);
    wb(0, OFS_STATUS, 0);
    c = q[24:8];
    wb(1, OFS_CTRL, 32'h2);
    repeat (200) @(posedge clk);
    wb(0, OFS_STATUS, 0);
    check_in("idle count", c, c + 8, q[24:8]);
    pulse_wake();
    wb(0, OFS_STATUS, 0);
    check_in("idle exit count", 0, 8, q[24:8]);
    wb(0, OFS_STATUS, 0);
    c = q[24:8];
    wb(1, OFS_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    pulse_wake();
    wb(0, OFS_STATUS, 0);
    check_in("halt resume", c, c + 10, q[24:8]);
    wb(1, OFS_CTRL, 32'h5);
    repeat (30) @(posedge clk);
    pulse_wake();
    wb(0, OFS_STATUS, 0);
    check_in("halt restart", 0, 8, q[24:8]);
    // crystal option without startup delay must also restart the window
    repeat (50) @(posedge clk);
    wb(1, OFS_CTRL, 32'h9);
    repeat (30) @(posedge clk);
    pulse_wake();
    wb(0, OFS_STATUS, 0);
    check_in("xtal restart", 0, 8, q[24:8]);
    $display("test low power done");
    // second reset: idle timer survives, monitor catches a halt
    wb(0, OFS_IDLE, 0);
    c = q[15:0];
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    m_win = 3;
    m_cm = 1;
    wb(0, OFS_IDLE, 0);
    check_in("idle carry", c, c + 20, q[15:0]);
    wb(0, OFS_SERVICE, 0);
    check("service", exp_svc(), q);
    wb(1, OFS_CTRL, 32'h1);
    wait_oe(0, 150);
    pulse_wake();
    wait_oe(1, 400);
    $display("test second reset done");
    // three mismatches, one early, one late, one monitor error
    check("fault events", 6, events);
    complete_run();
  end
endmodule
`default_nettype wire
